// *** core/tmcp_pkg.sv ***
/*
 * Constants, states and carrier types of the temporary-message code parser.
 * Assumes a 25 MHz system clock and characters delivered by on-chip logic.
 */
package tmcp_pkg;
	// timing
	localparam int unsigned CLK_HZ    = 25_000_000;
	localparam int unsigned TICK_MS   = 10;
	localparam int unsigned TICK_CYC  = CLK_HZ / 1000 * TICK_MS;
	localparam int unsigned BUF_DEPTH = 128;
	// introducers and code characters
	localparam logic [7:0] CC_US    = 8'h1f;
	localparam logic [7:0] CC_CARET = 8'h5e;
	localparam logic [7:0] OP_BLINK = 8'h20;
	localparam logic [7:0] OP_TIME  = 8'h21;
	localparam logic [7:0] OP_TMR   = 8'h22;
	localparam logic [7:0] OP_PIN   = 8'h23;
	localparam logic [7:0] OP_MTO   = 8'h24;
	localparam logic [7:0] OP_PTO   = 8'h25;
	localparam logic [7:0] OP_BLK   = 8'h26;
	localparam logic [7:0] OP_CHR   = 8'h27;
	localparam logic [7:0] OP_TERM  = 8'h28;
	localparam logic [7:0] OP_EOB   = 8'h29;
	localparam logic [7:0] OP_EOL   = 8'h2b;
	localparam logic [7:0] EXT_OFS  = 8'h50;
	localparam logic [7:0] EXT_LO   = 8'h80;
	localparam logic [7:0] EXT_HI   = 8'hb8;
	localparam logic [7:0] CH_0     = 8'h30;
	localparam logic [7:0] CH_9     = 8'h39;
	localparam logic [7:0] CH_ON    = 8'h4e;
	localparam logic [7:0] CH_UP    = 8'h55;
	localparam logic [7:0] CH_CLR   = 8'h56;
	// time-out coding
	localparam logic [9:0]  MTO_MS     = 10'h080;
	localparam logic [9:0]  MTO_MIN    = 10'h040;
	localparam logic [9:0]  MTO_NONE   = 10'h0ff;
	localparam logic [19:0] TK_PER_S   = 20'h00064;
	localparam logic [19:0] TK_PER_MIN = 20'h01770;
	localparam logic [5:0]  PTO_MAX    = 6'h3f;
	// year window
	localparam logic [7:0]  YR_PIVOT = 8'h50;
	localparam logic [11:0] YR_1900  = 12'h76c;
	localparam logic [11:0] YR_2000  = 12'h7d0;
	// field lengths
	localparam logic [4:0] NUM_DIG  = 5'h03;
	localparam logic [4:0] TIME_DIG = 5'h10;
	localparam logic [4:0] TMR_DIG  = 5'h0a;
	localparam logic [4:0] FLAG_CNT = 5'h03;
	// scroll modes
	localparam logic [1:0] SCR_NONE = 2'h0;
	localparam logic [1:0] SCR_BLK  = 2'h1;
	localparam logic [1:0] SCR_CHR  = 2'h2;

	typedef enum logic [2:0] {ST_RX = 3'b000, ST_SCAN = 3'b001, ST_PIN = 3'b010,
		ST_SCRL = 3'b011, ST_SHOW = 3'b100} tmcp_state_t;
	typedef enum logic [2:0] {PC_TEXT = 3'b000, PC_CODE = 3'b001, PC_NUM = 3'b010,
		PC_FLAG = 3'b011, PC_DIG = 3'b100, PC_FMT = 3'b101, PC_FCODE = 3'b110} tmcp_ctx_t;
	typedef enum logic [1:0] {TK_TEXT = 2'h0, TK_EOB = 2'h1, TK_FTIME = 2'h2,
		TK_FTMR = 2'h3} tmcp_kind_t;

	typedef struct packed {
		tmcp_kind_t kind;
		logic       line;
		logic       blink;
		logic [7:0] ch;
	} tmcp_txt_t;
	typedef struct packed {
		logic unlock;
		logic on;
		logic off;
		logic toggle;
		logic lock;
		logic halt;
		logic run_def;
		logic run_msg;
	} tmcp_pin_act_t;
	typedef struct packed {
		logic          act_valid;
		tmcp_pin_act_t act;
		logic          to_valid;
		logic [5:0]    to_sec;
	} tmcp_pin_t;
	typedef struct packed {
		logic [7:0]  hund;
		logic [7:0]  sec;
		logic [7:0]  min;
		logic [7:0]  hour;
		logic [7:0]  wday;
		logic [7:0]  mday;
		logic [7:0]  month;
		logic [11:0] year;
		logic        fmt;
	} tmcp_clk_t;
	typedef struct packed {
		logic [9:0] num;
		logic       on;
		logic       up;
		logic       clr_ovf;
		logic [7:0] hund;
		logic [7:0] sec;
		logic [7:0] min;
		logic [7:0] hr_hi;
		logic [7:0] hr_lo;
		logic       fmt;
	} tmcp_tmr_t;
endpackage

// *** core/tmcp_parser.sv ***
/*
 * Temporary-message control-code parser: buffers one string, walks it twice
 * after the terminator, emits text, pin, clock, timer, scroll and show events
 * in order, and runs the message time-out.
 * Assumes a same-clock character source that honours o_rx_ready, and a
 * display, clock and timer block downstream that take one-cycle pulses.
 */
module tmcp_parser #(
	parameter int unsigned DEPTH    = tmcp_pkg::BUF_DEPTH,
	parameter int unsigned TICK_CYC = tmcp_pkg::TICK_CYC
) (
	// clock and reset
	input  wire logic                i_clk,
	input  wire logic                i_nrst,
	// received characters
	input  wire logic                i_rx_valid,
	input  wire logic [7:0]          i_rx_char,
	output logic                     o_rx_ready,
	// configuration and display requests
	input  wire logic [7:0]          i_term,
	input  wire logic                i_msg_cancel,
	input  wire logic                i_disp_req,
	// decoded events
	output logic                     o_txt_valid,
	output tmcp_pkg::tmcp_txt_t      o_txt,
	output logic                     o_pin_valid,
	output tmcp_pkg::tmcp_pin_t      o_pin,
	output logic                     o_clk_valid,
	output tmcp_pkg::tmcp_clk_t      o_clk,
	output logic                     o_tmr_valid,
	output tmcp_pkg::tmcp_tmr_t      o_tmr,
	output logic                     o_scrl_valid,
	output logic [3:0]               o_scrl,
	output logic                     o_show,
	// message state
	output logic                     o_msg_active,
	output logic                     o_msg_expire
);
	localparam int AW = $clog2(DEPTH);
	localparam int DW = $clog2(TICK_CYC);

	////////////////////////////////////////////////////////////////////////////
	// reset release
	logic [1:0] rst_q;
	logic       rst_n;

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rst_q <= 2'h0;
		end else begin
			rst_q <= {rst_q[0], 1'b1};
		end
	end
	assign rst_n = rst_q[1];

	////////////////////////////////////////////////////////////////////////////
	// string buffer and parser
	logic [7:0]            mem_q [DEPTH];
	logic                  we;
	tmcp_pkg::tmcp_state_t st_q, st_d;
	tmcp_pkg::tmcp_ctx_t   pc_q, pc_d;
	logic                  pass_q, pass_d;
	logic [AW:0]           wr_q, wr_d, rd_q, rd_d;
	logic [7:0]            op_q, op_d;
	logic [4:0]            cnt_q, cnt_d;
	logic [9:0]            acc_q, acc_d;
	logic [63:0]           bcd_q, bcd_d;
	logic [2:0]            flg_q, flg_d;
	logic                  fmt_q, fmt_d, blink_q, blink_d, line_q, line_d;
	logic [9:0]            mto_q, mto_d;
	tmcp_pkg::tmcp_pin_t   pinc_q, pinc_d;
	logic [3:0]            scr_q, scr_d;
	logic                  txv_q, txv_d, pnv_q, pnv_d, ckv_q, ckv_d;
	logic                  tmv_q, tmv_d, scv_q, scv_d, show_q, show_d;
	tmcp_pkg::tmcp_txt_t   txt_q, txt_d;
	tmcp_pkg::tmcp_clk_t   clk_q, clk_d;
	tmcp_pkg::tmcp_tmr_t   tmr_q, tmr_d;
	logic [7:0]            c, yy;
	logic                  intro, is_dig;

	assign c      = mem_q[rd_q[AW-1:0]];
	assign intro  = (c == tmcp_pkg::CC_US) || (c == tmcp_pkg::CC_CARET);
	assign is_dig = (c >= tmcp_pkg::CH_0) && (c <= tmcp_pkg::CH_9);
	assign yy     = {4'h0, bcd_q[7:4]} * 8'h0a + {4'h0, bcd_q[3:0]};

	// next-state of the buffer and parser
	always_comb begin
		st_d = st_q;
		pc_d = pc_q;
		pass_d = pass_q;
		wr_d = wr_q;
		rd_d = rd_q;
		op_d = op_q;
		cnt_d = cnt_q;
		acc_d = acc_q;
		bcd_d = bcd_q;
		flg_d = flg_q;
		fmt_d = fmt_q;
		blink_d = blink_q;
		line_d = line_q;
		mto_d = mto_q;
		pinc_d = pinc_q;
		scr_d = scr_q;
		txt_d = txt_q;
		clk_d = clk_q;
		tmr_d = tmr_q;
		txv_d = 1'b0;
		pnv_d = 1'b0;
		ckv_d = 1'b0;
		tmv_d = 1'b0;
		scv_d = 1'b0;
		show_d = 1'b0;
		we = 1'b0;
		txt_d.line = line_q;
		txt_d.blink = blink_q;
		case (st_q)
			tmcp_pkg::ST_RX: begin
				if (i_rx_valid && (i_rx_char == i_term)) begin
					st_d = tmcp_pkg::ST_SCAN;
					pass_d = 1'b0;
					rd_d = '0;
					pc_d = tmcp_pkg::PC_TEXT;
					blink_d = 1'b0;
					line_d = 1'b0;
					mto_d = tmcp_pkg::MTO_NONE;
					pinc_d = '0;
					scr_d = {tmcp_pkg::SCR_NONE, tmcp_pkg::SCR_NONE};
				end else if (i_rx_valid && (wr_q < (AW+1)'(DEPTH))) begin
					we = 1'b1;
					wr_d = wr_q + 1'b1;
				end
			end
			tmcp_pkg::ST_SCAN: begin
				if (rd_q == wr_q) begin
					st_d = pass_q ? tmcp_pkg::ST_SCRL : tmcp_pkg::ST_PIN;
				end else begin
					rd_d = rd_q + 1'b1;
					case (pc_q)
						tmcp_pkg::PC_TEXT: begin
							if (intro) begin
								pc_d = tmcp_pkg::PC_CODE;
							end else begin
								txt_d.kind = tmcp_pkg::TK_TEXT;
								txt_d.ch = c;
								txv_d = !pass_q;
							end
						end
						tmcp_pkg::PC_CODE: begin
							pc_d = tmcp_pkg::PC_TEXT;
							acc_d = '0;
							op_d = c;
							cnt_d = tmcp_pkg::NUM_DIG;
							case (c)
								tmcp_pkg::OP_BLINK: blink_d = !blink_q;
								tmcp_pkg::OP_TIME: begin
									cnt_d = tmcp_pkg::TIME_DIG;
									pc_d = tmcp_pkg::PC_DIG;
								end
								tmcp_pkg::OP_TMR, tmcp_pkg::OP_PIN, tmcp_pkg::OP_MTO,
								tmcp_pkg::OP_PTO: pc_d = tmcp_pkg::PC_NUM;
								tmcp_pkg::OP_BLK: begin
									if (line_q) scr_d[3:2] = tmcp_pkg::SCR_BLK;
									else scr_d[1:0] = tmcp_pkg::SCR_BLK;
								end
								tmcp_pkg::OP_CHR: begin
									if (line_q) scr_d[3:2] = tmcp_pkg::SCR_CHR;
									else scr_d[1:0] = tmcp_pkg::SCR_CHR;
								end
								tmcp_pkg::OP_TERM: begin
									txt_d.kind = tmcp_pkg::TK_TEXT;
									txt_d.ch = i_term;
									txv_d = !pass_q;
								end
								tmcp_pkg::OP_EOB: begin
									txt_d.kind = tmcp_pkg::TK_EOB;
									txt_d.ch = c;
									txv_d = !pass_q;
								end
								tmcp_pkg::OP_EOL: begin
									line_d = 1'b1;
									txt_d.line = 1'b1;
								end
								default: begin
									// seven-bit form of an extended character
									if (c + tmcp_pkg::EXT_OFS >= tmcp_pkg::EXT_LO &&
										c + tmcp_pkg::EXT_OFS <= tmcp_pkg::EXT_HI &&
										c < tmcp_pkg::EXT_LO) begin
										txt_d.kind = tmcp_pkg::TK_TEXT;
										txt_d.ch = c + tmcp_pkg::EXT_OFS;
										txv_d = !pass_q;
									end
									// any other code is dropped
								end
							endcase
						end
						tmcp_pkg::PC_NUM: begin
							if (!is_dig) begin
								pc_d = tmcp_pkg::PC_TEXT; // malformed value skipped
							end else begin
								acc_d = 10'(acc_q * 10'h00a + {6'h00, c[3:0]});
								cnt_d = cnt_q - 1'b1;
								if (cnt_q == 5'h01) begin
									pc_d = tmcp_pkg::PC_TEXT;
									case (op_q)
										tmcp_pkg::OP_MTO: mto_d = acc_d;
										tmcp_pkg::OP_PIN: begin
											pinc_d.act_valid = 1'b1;
											pinc_d.act = acc_d[7:0];
										end
										tmcp_pkg::OP_PTO: begin
											pinc_d.to_valid = 1'b1;
											pinc_d.to_sec = (acc_d > 10'(tmcp_pkg::PTO_MAX)) ?
												tmcp_pkg::PTO_MAX : acc_d[5:0];
										end
										default: begin // timer number
											tmr_d.num = acc_d;
											cnt_d = tmcp_pkg::FLAG_CNT;
											pc_d = tmcp_pkg::PC_FLAG;
										end
									endcase
								end
							end
						end
						tmcp_pkg::PC_FLAG: begin
							flg_d = {flg_q[1:0], 1'b0};
							flg_d[0] = (cnt_q == 5'h03) ? (c == tmcp_pkg::CH_ON) :
								(cnt_q == 5'h02) ? (c == tmcp_pkg::CH_UP) :
								(c == tmcp_pkg::CH_CLR);
							cnt_d = cnt_q - 1'b1;
							if (cnt_q == 5'h01) begin
								cnt_d = tmcp_pkg::TMR_DIG;
								pc_d = tmcp_pkg::PC_DIG;
							end
						end
						tmcp_pkg::PC_DIG: begin
							if (!is_dig) begin
								pc_d = tmcp_pkg::PC_TEXT;
							end else begin
								bcd_d = {bcd_q[59:0], c[3:0]};
								cnt_d = cnt_q - 1'b1;
								if (cnt_q == 5'h01) begin
									fmt_d = 1'b0;
									pc_d = tmcp_pkg::PC_FMT;
								end
							end
						end
						tmcp_pkg::PC_FMT: begin
							if (intro) begin
								pc_d = tmcp_pkg::PC_FCODE;
							end else begin
								// format text marks where the value is shown
								fmt_d = 1'b1;
								txt_d.kind = (op_q == tmcp_pkg::OP_TIME) ?
									tmcp_pkg::TK_FTIME : tmcp_pkg::TK_FTMR;
								txt_d.ch = c;
								txv_d = !pass_q;
							end
						end
						tmcp_pkg::PC_FCODE: begin
							pc_d = tmcp_pkg::PC_FMT;
							if (c == op_q && op_q == tmcp_pkg::OP_TIME) begin
								pc_d = tmcp_pkg::PC_TEXT;
								clk_d.hund = bcd_q[63:56];
								clk_d.sec = bcd_q[55:48];
								clk_d.min = bcd_q[47:40];
								clk_d.hour = bcd_q[39:32];
								clk_d.wday = bcd_q[31:24];
								clk_d.mday = bcd_q[23:16];
								clk_d.month = bcd_q[15:8];
								clk_d.year = (yy >= tmcp_pkg::YR_PIVOT) ?
									tmcp_pkg::YR_1900 + {4'h0, yy} :
									tmcp_pkg::YR_2000 + {4'h0, yy};
								clk_d.fmt = fmt_q;
								ckv_d = pass_q;
							end else if (c == op_q) begin
								pc_d = tmcp_pkg::PC_TEXT;
								{tmr_d.on, tmr_d.up, tmr_d.clr_ovf} = flg_q;
								tmr_d.hund = bcd_q[39:32];
								tmr_d.sec = bcd_q[31:24];
								tmr_d.min = bcd_q[23:16];
								tmr_d.hr_hi = bcd_q[15:8];
								tmr_d.hr_lo = bcd_q[7:0];
								tmr_d.fmt = fmt_q;
								tmv_d = pass_q;
							end
						end
						default: pc_d = tmcp_pkg::PC_TEXT;
					endcase
				end
			end
			tmcp_pkg::ST_PIN: begin
				// pin first, then a second walk for clock and timer loads
				pnv_d = pinc_q.act_valid || pinc_q.to_valid;
				pass_d = 1'b1;
				rd_d = '0;
				pc_d = tmcp_pkg::PC_TEXT;
				blink_d = 1'b0;
				line_d = 1'b0;
				st_d = tmcp_pkg::ST_SCAN;
			end
			tmcp_pkg::ST_SCRL: begin
				scv_d = 1'b1;
				st_d = tmcp_pkg::ST_SHOW;
			end
			tmcp_pkg::ST_SHOW: begin
				show_d = 1'b1;
				wr_d = '0;
				st_d = tmcp_pkg::ST_RX;
			end
			default: st_d = tmcp_pkg::ST_RX;
		endcase
	end

	// buffer write, no reset needed on storage
	always_ff @(posedge i_clk) begin
		if (we) begin
			mem_q[wr_q[AW-1:0]] <= i_rx_char;
		end
	end

	// parser registers
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= tmcp_pkg::ST_RX;
			pc_q <= tmcp_pkg::PC_TEXT;
			pass_q <= 1'b0;
			wr_q <= '0;
			rd_q <= '0;
			op_q <= 8'h00;
			cnt_q <= 5'h00;
			acc_q <= 10'h000;
			bcd_q <= 64'h0;
			flg_q <= 3'h0;
			fmt_q <= 1'b0;
			blink_q <= 1'b0;
			line_q <= 1'b0;
			mto_q <= tmcp_pkg::MTO_NONE;
			pinc_q <= '0;
			scr_q <= 4'h0;
			txt_q <= '0;
			clk_q <= '0;
			tmr_q <= '0;
			txv_q <= 1'b0;
			pnv_q <= 1'b0;
			ckv_q <= 1'b0;
			tmv_q <= 1'b0;
			scv_q <= 1'b0;
			show_q <= 1'b0;
		end else begin
			st_q <= st_d;
			pc_q <= pc_d;
			pass_q <= pass_d;
			wr_q <= wr_d;
			rd_q <= rd_d;
			op_q <= op_d;
			cnt_q <= cnt_d;
			acc_q <= acc_d;
			bcd_q <= bcd_d;
			flg_q <= flg_d;
			fmt_q <= fmt_d;
			blink_q <= blink_d;
			line_q <= line_d;
			mto_q <= mto_d;
			pinc_q <= pinc_d;
			scr_q <= scr_d;
			txt_q <= txt_d;
			clk_q <= clk_d;
			tmr_q <= tmr_d;
			txv_q <= txv_d;
			pnv_q <= pnv_d;
			ckv_q <= ckv_d;
			tmv_q <= tmv_d;
			scv_q <= scv_d;
			show_q <= show_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// message time-out
	logic [DW-1:0] div_q, div_d;
	logic [19:0]   left_q, left_d, load;
	logic          act_q, act_d, inf_q, inf_d, exp_q, exp_d, tick;

	assign tick = (div_q == DW'(TICK_CYC - 1));

	// decode the time-out value into 10 ms ticks
	always_comb begin
		if (mto_q >= tmcp_pkg::MTO_MS) begin
			load = 20'(mto_q - tmcp_pkg::MTO_MS);
		end else if (mto_q >= tmcp_pkg::MTO_MIN) begin
			load = 20'(mto_q - tmcp_pkg::MTO_MIN) * tmcp_pkg::TK_PER_MIN;
		end else begin
			load = 20'(mto_q) * tmcp_pkg::TK_PER_S;
		end
	end

	// run, expire and cancel the displayed message
	always_comb begin
		div_d = tick ? '0 : div_q + 1'b1;
		act_d = act_q;
		inf_d = inf_q;
		left_d = left_q;
		exp_d = 1'b0;
		if (show_q) begin
			div_d = '0; // restart the tick phase so the whole interval runs
			act_d = 1'b1;
			inf_d = (mto_q >= tmcp_pkg::MTO_NONE);
			left_d = load;
		end else if (i_msg_cancel || i_disp_req) begin
			act_d = 1'b0;
		end else if (act_q && !inf_q) begin
			if (left_q == 20'h0) begin
				act_d = 1'b0;
				exp_d = 1'b1;
			end else if (tick) begin
				left_d = left_q - 1'b1;
			end
		end
	end

	// time-out registers
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_q <= '0;
			left_q <= 20'h0;
			act_q <= 1'b0;
			inf_q <= 1'b0;
			exp_q <= 1'b0;
		end else begin
			div_q <= div_d;
			left_q <= left_d;
			act_q <= act_d;
			inf_q <= inf_d;
			exp_q <= exp_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs
	assign o_rx_ready = (st_q == tmcp_pkg::ST_RX);
	assign o_txt_valid = txv_q;
	assign o_txt = txt_q;
	assign o_pin_valid = pnv_q;
	assign o_pin = pinc_q;
	assign o_clk_valid = ckv_q;
	assign o_clk = clk_q;
	assign o_tmr_valid = tmv_q;
	assign o_tmr = tmr_q;
	assign o_scrl_valid = scv_q;
	assign o_scrl = scr_q;
	assign o_show = show_q;
	assign o_msg_active = act_q;
	assign o_msg_expire = exp_q;
endmodule

// *** tb/tmcp_host.sv ***
/*
 * Host model: sends one message string a character at a time, then the
 * terminator. Assumes the parser's ready is stable between clock edges.
 */
module tmcp_host (
	// clock and flow control
	input  wire logic i_clk,
	input  wire logic i_ready,
	// character lane
	output logic       o_valid,
	output logic [7:0] o_char
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle lane at time zero
	initial begin
		o_valid = 1'b0;
		o_char  = 8'h00;
	end

	// drive at a falling edge, hold until taken, gap+1 idle cycles between for a nonzero gap
	task automatic send(input string s, input logic [7:0] term, input int gap);
		logic [7:0] c;
		int         i;
		int         w;
		for (i = 0; i <= s.len(); i++) begin
			c = (i < s.len()) ? 8'(s[i]) : term;
			@(negedge i_clk);
			o_valid = 1'b1;
			o_char  = c;
			w = 0;
			while (!i_ready && w < 1000) begin // hold while refused
				@(negedge i_clk);
				w++;
			end
			@(posedge i_clk);
			if (gap > 0 || i == s.len()) begin
				@(negedge i_clk);
				o_valid = 1'b0;
				o_char  = ~c; // released lane shows no stale value
				repeat (gap) @(negedge i_clk);
			end
		end
	endtask
endmodule

// *** tb/tmcp_parser_sva.sv ***
/*
 * Port checker for the message code parser.
 * Assumes one clock domain and the parser's own port names.
 */
module tmcp_parser_sva #(
	parameter int unsigned DEPTH    = 128,
	parameter int unsigned TICK_CYC = 250000
) (
	input wire logic       i_clk,
	input wire logic       i_nrst,
	input wire logic       i_rx_valid,
	input wire logic [7:0] i_rx_char,
	input wire logic       o_rx_ready,
	input wire logic [7:0] i_term,
	input wire logic       i_msg_cancel,
	input wire logic       i_disp_req,
	input wire logic       o_txt_valid,
	input wire logic       o_pin_valid,
	input wire logic       o_clk_valid,
	input wire logic       o_tmr_valid,
	input wire logic       o_scrl_valid,
	input wire logic       o_show,
	input wire logic       o_msg_active,
	input wire logic       o_msg_expire
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);

	////////////////////////////////////////////////////////////////////////
	// busy window and event order
	a_ready_drop: assert property (o_rx_ready && i_rx_valid && i_rx_char == i_term
		|=> !o_rx_ready) else $error("ready stays high after terminator");
	a_busy_bound: assert property ($fell(o_rx_ready) |-> ##[4:300] o_show)
		else $error("processing too long");
	a_ready_show: assert property ($rose(o_rx_ready) |-> o_show)
		else $error("ready back without show");
	a_events_busy: assert property (o_txt_valid || o_pin_valid || o_clk_valid
		|| o_tmr_valid || o_scrl_valid |-> !o_rx_ready)
		else $error("event while receiving");
	a_pin_order: assert property (o_pin_valid |-> ##[2:300] o_scrl_valid)
		else $error("pin not before scroll");
	a_load_order: assert property (o_clk_valid || o_tmr_valid
		|-> ##[1:300] o_scrl_valid) else $error("load not before scroll");
	a_show_last: assert property (o_show |-> $past(o_scrl_valid))
		else $error("show not after scroll");

	////////////////////////////////////////////////////////////////////////
	// message lifetime
	a_show_active: assert property (o_show |=> o_msg_active)
		else $error("message not active after show");
	a_expire_drop: assert property (o_msg_expire
		|-> !o_msg_active && $past(o_msg_active)) else $error("expire without active drop");
	a_cancel_quiet: assert property (o_msg_active && !o_show
		&& (i_msg_cancel || i_disp_req)
		|=> !o_msg_active && !o_msg_expire) else $error("cancel failed");
	a_active_hold: assert property (o_msg_active && !i_msg_cancel && !i_disp_req
		|=> o_msg_active || o_msg_expire) else $error("message lost");

	c_show: cover property (o_show);
	c_expire: cover property (o_msg_expire);
	c_clock: cover property (o_clk_valid);
	c_timer: cover property (o_tmr_valid);
endmodule

bind tmcp_parser tmcp_parser_sva #(.DEPTH(DEPTH), .TICK_CYC(TICK_CYC)) u_sva (
	.i_clk(i_clk), .i_nrst(i_nrst), .i_rx_valid(i_rx_valid), .i_rx_char(i_rx_char),
	.o_rx_ready(o_rx_ready), .i_term(i_term), .i_msg_cancel(i_msg_cancel),
	.i_disp_req(i_disp_req), .o_txt_valid(o_txt_valid), .o_pin_valid(o_pin_valid),
	.o_clk_valid(o_clk_valid), .o_tmr_valid(o_tmr_valid), .o_scrl_valid(o_scrl_valid),
	.o_show(o_show), .o_msg_active(o_msg_active), .o_msg_expire(o_msg_expire));

// *** tb/tmcp_parser_tb.sv ***
/*
 * Self-checking bench for the message code parser.
 * Assumes the host model and a 10-cycle time-out tick.
 */
module tmcp_parser_tb;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [7:0] TERM = 8'h2a;
	logic i_clk, i_nrst, i_rx_valid, o_rx_ready, i_msg_cancel, i_disp_req;
	logic [7:0] i_rx_char;
	logic o_txt_valid, o_pin_valid, o_clk_valid, o_tmr_valid, o_scrl_valid;
	logic o_show, o_msg_active, o_msg_expire;
	logic [3:0] o_scrl;
	tmcp_pkg::tmcp_txt_t o_txt;
	tmcp_pkg::tmcp_pin_t o_pin;
	tmcp_pkg::tmcp_clk_t o_clk;
	tmcp_pkg::tmcp_tmr_t o_tmr;
	tmcp_pkg::tmcp_txt_t txt_q[$];
	int n_fail, n_tests, n_exp, n_eob, n_load, n_fmt, n_pin;

	tmcp_parser #(.DEPTH(32), .TICK_CYC(10)) u_dut (.i_clk(i_clk), .i_nrst(i_nrst),
		.i_rx_valid(i_rx_valid), .i_rx_char(i_rx_char), .o_rx_ready(o_rx_ready),
		.i_term(TERM), .i_msg_cancel(i_msg_cancel), .i_disp_req(i_disp_req),
		.o_txt_valid(o_txt_valid), .o_txt(o_txt), .o_pin_valid(o_pin_valid),
		.o_pin(o_pin), .o_clk_valid(o_clk_valid), .o_clk(o_clk),
		.o_tmr_valid(o_tmr_valid), .o_tmr(o_tmr), .o_scrl_valid(o_scrl_valid),
		.o_scrl(o_scrl), .o_show(o_show), .o_msg_active(o_msg_active),
		.o_msg_expire(o_msg_expire));
	tmcp_host u_host (.i_clk(i_clk), .i_ready(o_rx_ready), .o_valid(i_rx_valid),
		.o_char(i_rx_char));

	// clock
	initial begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end

	// collect text items, block ends and expiries mid-cycle
	always @(negedge i_clk) begin
		if (o_txt_valid && o_txt.kind === tmcp_pkg::TK_TEXT)
			txt_q.push_back(o_txt);
		if (o_txt_valid && o_txt.kind === tmcp_pkg::TK_EOB)
			n_eob++;
		if (o_msg_expire)
			n_exp++;
		if (o_txt_valid && o_txt.kind inside {tmcp_pkg::TK_FTIME, tmcp_pkg::TK_FTMR})
			n_fmt++;
		if (o_clk_valid || o_tmr_valid)
			n_load++;
		if (o_pin_valid)
			n_pin++;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [127:0] seen, input logic [127:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic test_done();
		$display("tests %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// send one string and wait for the show pulse
	task automatic run(input string s, input int gap);
		int k;
		txt_q.delete();
		n_exp = 0;
		n_eob = 0;
		n_load = 0;
		n_fmt = 0;
		n_pin = 0;
		u_host.send(s, TERM, gap);
		k = 0;
		while (o_show !== 1'b1 && k < 400) begin
			@(negedge i_clk);
			k++;
		end
		check(k < 400, 1'b1);
	endtask

	function automatic tmcp_pkg::tmcp_txt_t mk(input logic ln, input logic bl,
		input logic [7:0] c);
		return '{tmcp_pkg::TK_TEXT, ln, bl, c};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// no time-out: stays until cancel or display request
	task automatic t_hold(input logic use_disp);
		run("AB", 2);
		repeat (300) @(negedge i_clk);
		check(o_msg_active, 1'b1);
		if (use_disp) i_disp_req = 1'b1;
		else i_msg_cancel = 1'b1;
		@(negedge i_clk);
		i_disp_req   = 1'b0;
		i_msg_cancel = 1'b0;
		@(negedge i_clk);
		check({o_msg_active, n_exp != 0}, 2'h0);
	endtask

	// zero seconds: shown, then expires at once
	task automatic t_zero();
		run("^$000Z", 0);
		repeat (4) @(negedge i_clk);
		check({o_msg_active, 8'(n_exp)}, 9'h001);
	endtask

	// timed message stays for its full tick count, then expires
	task automatic t_timeout(input string s, input int ticks);
		int k;
		run(s, 0);
		repeat (ticks * 10) @(negedge i_clk);
		check({o_msg_active, n_exp != 0}, 2'h2);
		k = 0;
		while (n_exp == 0 && k < 30) begin
			@(negedge i_clk);
			k++;
		end
		check({o_msg_active, 8'(n_exp)}, 9'h001);
	endtask

	// pin weights and clamped pin time-out
	task automatic t_pin();
		run("^#202^%070P", 0);
		check(o_pin, {1'b1, 8'hca, 1'b1, 6'h3f});
		check(n_pin, 1);
		run("^#053Q", 0);
		check(o_pin.act, 8'h35);
	endtask

	// clock loads, year window and format flag
	task automatic t_clock();
		run("^!0000151003261093^!T", 0);
		check(o_clk, {32'h00001510, 24'h032610, 12'h7c9, 1'b0});
		check({8'(n_load), 8'(n_fmt), 8'(txt_q.size())}, 24'h010001);
		run("^!9959592307311279HA^!", 0);
		check(o_clk, {32'h99595923, 24'h073112, 12'h81f, 1'b1});
		check({8'(n_load), 8'(n_fmt), 8'(txt_q.size())}, 24'h010200);
	endtask

	// elapsed timer loads and flags
	task automatic t_timer();
		run("^\"010ND 0000000100HL^\"X", 0);
		check(o_tmr, {10'h00a, 3'h4, 40'h0000000100, 1'b1});
		check({8'(n_load), 8'(n_fmt), 8'(txt_q.size())}, 24'h010201);
		run("^\"255FUV1234563412^\"", 0);
		check(o_tmr, {10'h0ff, 3'h3, 40'h1234563412, 1'b0});
		check({8'(n_load), 8'(n_fmt), 8'(txt_q.size())}, 24'h010000);
	endtask

	// scrolling, block end, terminator, extended, unknown and blink codes
	task automatic t_text();
		run("^&a^)^(\0371^,^ b^ ^+^'c", 0);
		check(o_scrl, 4'h9);
		check(n_eob != 0, 1'b1);
		check(txt_q.size(), 5);
		check(txt_q[0], mk(1'b0, 1'b0, 8'h61));
		check(txt_q[1], mk(1'b0, 1'b0, TERM));
		check(txt_q[2], mk(1'b0, 1'b0, 8'h81));
		check(txt_q[3], mk(1'b0, 1'b1, 8'h62));
		check(txt_q[4], mk(1'b1, 1'b0, 8'h63));
	endtask

	////////////////////////////////////////////////////////////////////////
	// watchdog
	initial begin
		#(80000 * 40);
		n_fail++;
		test_done();
	end

	// main sequence
	initial begin
		i_nrst       = 1'b0;
		i_msg_cancel = 1'b0;
		i_disp_req   = 1'b0;
		repeat (6) @(negedge i_clk);
		i_nrst = 1'b1;
		repeat (3) @(negedge i_clk);
		check({o_rx_ready, o_msg_active, o_show}, 3'h4);
		t_hold(1'b0);
		t_hold(1'b1);
		t_zero();
		t_timeout("^$130", 2);
		t_timeout("\037$001", 100);
		t_timeout("^$065", 6000);
		t_pin();
		t_clock();
		t_timer();
		t_text();
		test_done();
	end
endmodule
